// >>> logic/csfc_core.sv
// Capacitive sense frequency counter top with AXI4-Lite register slave.
`timescale 1ns/1ns
// Function
// R1 - Without reference select the oscillator stays in low range only.
// R2 - Oscillator clocks exactly one selected timer during the window.
// R3 - Window source must not be the timer the oscillator clocks.
// R4 - First timer uses oscillator when its select set and clock bit clear.
// R5 - Second timer clock field 11 selects the sense oscillator.
// R6 - Second timer off when on is 0; gated when gate enable set.
// R7 - Window best made from first timer overflow and gate toggle.
// R8 - Software clears timer at window start, captures count at end.
// R9 - Frequency equals captured count divided by window length.
// R10 - Same window for loaded and unloaded; loaded gives lower count.
// R11 - Threshold placed midway between unloaded and loaded frequency.
// R12 - Oscillator keeps running in sleep while the unit is enabled.
// R13 - Timer counts in sleep; comparison only after wake.
// R14 - First timer does not count during sleep.
// R15 - Reference select set picks high range, clear picks low range.
// R16 - Range field 00..11 off/low/med/high; high range 00 is noise.
// R17 - Read-only phase bit shows sourcing or sinking.
// R18 - Timer increments once per synchronised oscillator cycle.
module csfc_core import csfc_pkg::*; #(
  parameter bit HAS_REFSEL = 1'b1
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // AXI4-Lite slave.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Sense pin and system.
  input wire logic sense_pin,
  input wire logic sleep_state,
  input wire logic second_timer_gate,
  // Analogue control outputs.
  output logic osc_run_r,
  output logic high_range_r,
  output logic [2:0] osc_mode_r
);
  logic [7:0] sense_control_0_r;
  logic first_timer_clock_source_bit_r;
  logic [7:0] second_timer_control_r;
  logic [15:0] tmr1_count_r;
  logic [15:0] tmr2_count_r;
  logic [7:0] aw_addr_r;
  logic aw_have_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic w_have_r;
  logic osc_level;
  logic osc_rise;
  logic gate_level;
  logic refsel;
  logic [1:0] rng;
  logic t1_osc;
  logic t2_osc;
  logic t2_run;
  logic do_write;
  csfc_edge_sync u_osc_sync (
    .clock(clock), .rst_n(rst_n), .async_in(sense_pin),
    .level_out(osc_level), .rise_out(osc_rise)
  );
  csfc_edge_sync u_gate_sync (
    .clock(clock), .rst_n(rst_n), .async_in(second_timer_gate),
    .level_out(gate_level), .rise_out()
  );
  function automatic csfc_mode_e range_mode(input logic hi, input logic [1:0] f);
    case (f)
      2'h0: range_mode = hi ? CSFC_MODE_NOISE : CSFC_MODE_OFF; // R16
      2'h1: range_mode = CSFC_MODE_LOW;
      2'h2: range_mode = CSFC_MODE_MED;
      default: range_mode = CSFC_MODE_HIGH;
    endcase
  endfunction : range_mode
  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] d,
    input logic [3:0] s);
    merge_byte = s[0] ? d[7:0] : old;
  endfunction : merge_byte
  // Variants without the select bit force the fixed references.
  assign refsel = HAS_REFSEL & sense_control_0_r[CSFC_BIT_REFSEL]; // R1
  assign rng = sense_control_0_r[CSFC_BIT_RNG_LO +: 2];
  // Second timer wins when both are routed, so one timer only is clocked.
  assign t2_osc = second_timer_control_r[CSFC_BIT_T2CS_LO +: 2] == CSFC_T2CS_OSC; // R5
  assign t1_osc = sense_control_0_r[CSFC_BIT_T1XSEL] & ~first_timer_clock_source_bit_r
    & ~t2_osc; // R2 R4
  assign t2_run = second_timer_control_r[CSFC_BIT_T2ON]
    & (~second_timer_control_r[CSFC_BIT_T2GE] | gate_level); // R6
  assign do_write = aw_have_r & w_have_r & ~s_axi_bvalid;
  // Analogue controls; sleep is ignored here so the oscillator keeps running.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      osc_run_r <= 1'b0;
      high_range_r <= 1'b0;
      osc_mode_r <= 3'h0;
    end else begin
      osc_run_r <= sense_control_0_r[CSFC_BIT_ENABLE]; // R12
      high_range_r <= refsel; // R15
      osc_mode_r <= range_mode(refsel, rng); // R16
    end
  end
  // First timer halts in sleep; counts reflect whole oscillator cycles.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tmr1_count_r <= CSFC_RST_COUNT;
    end else if (do_write && aw_addr_r == CSFC_OFF_TMR1_COUNT) begin
      tmr1_count_r <= w_data_r[15:0]; // R8
    end else if (t1_osc && osc_rise && !sleep_state) begin
      tmr1_count_r <= tmr1_count_r + 16'h0001; // R14 R18
    end
  end
  // Second timer accumulates through sleep.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tmr2_count_r <= CSFC_RST_COUNT;
    end else if (do_write && aw_addr_r == CSFC_OFF_TMR2_COUNT) begin
      tmr2_count_r <= w_data_r[15:0];
    end else if (t2_osc && t2_run && osc_rise) begin
      tmr2_count_r <= tmr2_count_r + 16'h0001; // R13 R18
    end
  end
  // Control registers.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sense_control_0_r <= CSFC_RST_CTRL0;
      second_timer_control_r <= CSFC_RST_TMR2_CTRL;
      first_timer_clock_source_bit_r <= CSFC_RST_T1CS[CSFC_BIT_T1CS];
    end else if (do_write) begin
      if (aw_addr_r == CSFC_OFF_SENSE_CTRL0) begin
        sense_control_0_r <= merge_byte(sense_control_0_r, w_data_r, w_strb_r) & 8'hCD;
      end
      if (aw_addr_r == CSFC_OFF_TMR2_CTRL) begin
        second_timer_control_r <= merge_byte(second_timer_control_r, w_data_r, w_strb_r);
      end
      if (aw_addr_r == CSFC_OFF_CONFIG && w_strb_r[1]) begin
        first_timer_clock_source_bit_r <= w_data_r[CSFC_BIT_T1CS];
      end
    end
  end
  // Write channel: address and data taken in either order.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= CSFC_RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_have_r & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_have_r & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_r == CSFC_OFF_SENSE_CTRL0 || aw_addr_r == CSFC_OFF_TMR2_CTRL
          || aw_addr_r == CSFC_OFF_TMR1_COUNT || aw_addr_r == CSFC_OFF_TMR2_COUNT
          || aw_addr_r == CSFC_OFF_CONFIG) ? CSFC_RESP_OKAY : CSFC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Read channel; the phase bit is live so software sees the oscillator state.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= CSFC_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= CSFC_RESP_OKAY;
        case ({s_axi_araddr[7:2], 2'h0})
          CSFC_OFF_SENSE_CTRL0: s_axi_rdata <= {24'h000000,
            sense_control_0_r[7:2], osc_level, sense_control_0_r[0]}; // R17
          CSFC_OFF_TMR2_CTRL: s_axi_rdata <= {24'h000000, second_timer_control_r};
          CSFC_OFF_TMR1_COUNT: s_axi_rdata <= {16'h0000, tmr1_count_r}; // R9
          CSFC_OFF_TMR2_COUNT: s_axi_rdata <= {16'h0000, tmr2_count_r}; // R9
          CSFC_OFF_STATUS: s_axi_rdata <= {28'h0000000, t2_run, t2_osc, t1_osc, osc_level};
          CSFC_OFF_CONFIG: s_axi_rdata <= {23'h000000, first_timer_clock_source_bit_r,
            8'h00};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= CSFC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  a_one_timer: assert property (@(posedge clock) disable iff (!rst_n) // R2
    !do_write |=> !(tmr1_count_r != $past(tmr1_count_r) && tmr2_count_r != $past(tmr2_count_r)))
    else $error("both timers counted");
  a_t1_sleep: assert property (@(posedge clock) disable iff (!rst_n) // R14
    (sleep_state && !do_write) |=> $stable(tmr1_count_r)) else $error("t1 ran");
  a_t2_count: assert property (@(posedge clock) disable iff (!rst_n) // R5
    (t2_osc && t2_run && osc_rise && !do_write) |=> tmr2_count_r == $past(tmr2_count_r) + 16'h0001)
    else $error("t2 missed");
  a_t2_off: assert property (@(posedge clock) disable iff (!rst_n) // R6
    (!second_timer_control_r[CSFC_BIT_T2ON] && !do_write) |=> $stable(tmr2_count_r))
    else $error("t2 off ran");
  a_low_only: assert property (@(posedge clock) disable iff (!rst_n) // R1
    !HAS_REFSEL |-> !refsel) else $error("high range");
  a_noise_mode: assert property (@(posedge clock) disable iff (!rst_n) // R16
    (refsel && rng == 2'h0) |=> osc_mode_r == CSFC_MODE_NOISE) else $error("mode");
  a_run_sleep: assert property (@(posedge clock) disable iff (!rst_n) // R12
    sense_control_0_r[CSFC_BIT_ENABLE] |=> osc_run_r) else $error("osc stop");
  a_t1_count: assert property (@(posedge clock) disable iff (!rst_n) // R4
    (t1_osc && osc_rise && !sleep_state && !do_write) |=> tmr1_count_r != $past(tmr1_count_r))
    else $error("t1 missed");
  c_t1: cover property (@(posedge clock) t1_osc && osc_rise);
  c_t2_sleep: cover property (@(posedge clock) t2_osc && sleep_state && osc_rise);
  c_noise: cover property (@(posedge clock) osc_mode_r == CSFC_MODE_NOISE);
endmodule : csfc_core

// >>> pkg/csfc_pkg.sv
// Package for the capacitive sense frequency counter: register map, fields, resets.
package csfc_pkg;
  localparam logic [7:0] CSFC_OFF_SENSE_CTRL0 = 8'h00;
  localparam logic [7:0] CSFC_OFF_TMR2_CTRL = 8'h04;
  localparam logic [7:0] CSFC_OFF_TMR1_COUNT = 8'h08;
  localparam logic [7:0] CSFC_OFF_TMR2_COUNT = 8'h0C;
  localparam logic [7:0] CSFC_OFF_STATUS = 8'h10;
  localparam logic [7:0] CSFC_OFF_CONFIG = 8'h14;
  // Sense control word fields, then the clock source bit of the config word.
  localparam int CSFC_BIT_ENABLE = 7;
  localparam int CSFC_BIT_REFSEL = 6;
  localparam int CSFC_BIT_RNG_LO = 2;
  localparam int CSFC_BIT_PHASE = 1;
  localparam int CSFC_BIT_T1XSEL = 0;
  localparam int CSFC_BIT_T1CS = 8;
  // Second timer control fields.
  localparam int CSFC_BIT_T2ON = 0;
  localparam int CSFC_BIT_T2GE = 1;
  localparam int CSFC_BIT_T2CS_LO = 6;
  localparam logic [1:0] CSFC_T2CS_OSC = 2'h3;
  localparam logic [7:0] CSFC_RST_CTRL0 = 8'h00;
  localparam logic [7:0] CSFC_RST_TMR2_CTRL = 8'h00;
  localparam logic [8:0] CSFC_RST_T1CS = 9'h100;
  localparam logic [15:0] CSFC_RST_COUNT = 16'h0000;
  localparam logic [1:0] CSFC_RESP_OKAY = 2'h0;
  localparam logic [1:0] CSFC_RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {CSFC_MODE_OFF, CSFC_MODE_LOW, CSFC_MODE_MED, CSFC_MODE_HIGH,
    CSFC_MODE_NOISE} csfc_mode_e;
endpackage : csfc_pkg

// >>> logic/csfc_edge_sync.sv
// Two-stage synchroniser with rising-edge pulse for the oscillator pin.
`timescale 1ns/1ns
module csfc_edge_sync import csfc_pkg::*; (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Asynchronous level in, one-cycle edge out.
  input wire logic async_in,
  output logic level_out,
  output logic rise_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  assign level_out = s2_r;
  assign rise_out = s2_r & ~s3_r; // R18
endmodule : csfc_edge_sync

// >>> bench/csfc_pad_model.sv
// Touch pad electrode model: a relaxation oscillator that slows under touch load.
`timescale 1ns/1ns
module csfc_pad_model #(
  parameter int HALF_NS = 200,
  parameter int LOAD_NS = 300
) (
  // Controls from the device and the bench.
  input wire logic osc_run,
  input wire logic window,
  input wire logic loaded,
  // Comparator level seen at the pin.
  output logic sense_pin
);
  // The pad rests low between windows so that every count is exact.
  initial sense_pin = 1'b0;
  always begin
    wait (osc_run && window);
    #(loaded ? LOAD_NS : HALF_NS);
    sense_pin = !sense_pin;
    if (!(osc_run && window)) sense_pin = 1'b0;
  end
endmodule : csfc_pad_model

// >>> bench/tb_cap_sense_frequency_counter.sv
// Self-checking bench for the capacitive sense frequency counter.
`timescale 1ns/1ns
module tb_cap_sense_frequency_counter import csfc_pkg::*;;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic sleep_state = 1'b0;
  logic second_timer_gate = 1'b0;
  logic window = 1'b0;
  logic loaded = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic sense_pin, osc_run_r, high_range_r;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, data;
  logic [2:0] osc_mode_r, low_mode;
  logic low_run, low_high;
  logic [31:0] nominal;
  int failures = 0;
  int total_checks = 0;
  // Control word, then the high range flag and mode that it should select.
  logic [11:0] rows [8] = '{12'h800, 12'h841, 12'h882, 12'h8C3, 12'hC0C, 12'hC49, 12'hC8A,
    12'hCCB};

  always #20 clock = ~clock;

  csfc_core dut (.clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .sense_pin, .sleep_state, .second_timer_gate, .osc_run_r, .high_range_r,
    .osc_mode_r);
  csfc_pad_model pad (.osc_run(osc_run_r), .window, .loaded, .sense_pin);
  // Variant without the reference select bit, sharing the bus with the main instance.
  csfc_core #(.HAS_REFSEL(1'b0)) dut_low (.clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(),
    .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready,
    .sense_pin, .sleep_state, .second_timer_gate, .osc_run_r(low_run),
    .high_range_r(low_high), .osc_mode_r(low_mode));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clock);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clock);
  endtask : rd

  // A window of 200 cycles holds 20 unloaded or 13 loaded pad periods.
  task automatic meas(input logic [7:0] a, input logic ld, input logic [31:0] exp);
    wr(a, 32'h0);
    loaded <= ld;
    window <= 1'b1;
    repeat (200) @(posedge clock);
    window <= 1'b0;
    repeat (10) @(posedge clock);
    rd(a);
    chk(data, exp);
  endtask : meas

  task automatic stop_test;
    $display("Checks %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(CSFC_OFF_SENSE_CTRL0);
    chk(data, 32'h0);
    rd(CSFC_OFF_CONFIG);
    chk(data, 32'h100);
    for (int i = 0; i < 8; i++) begin
      wr(CSFC_OFF_SENSE_CTRL0, {24'h0, rows[i][11:4]});
      repeat (2) @(posedge clock);
      chk({27'h0, osc_run_r, high_range_r, osc_mode_r}, {28'h1, rows[i][3:0]});
      chk({27'h0, low_run, low_high, low_mode}, {28'h1, 2'h0, rows[i][7:6]});
    end
    rd(8'h18);
    chk(resp, CSFC_RESP_SLVERR);
    chk(data, 32'h0);
    wr(8'h18, 32'hFF);
    chk(resp, CSFC_RESP_SLVERR);
    wr(CSFC_OFF_SENSE_CTRL0, 32'h85);
    chk(resp, CSFC_RESP_OKAY);
    meas(CSFC_OFF_TMR1_COUNT, 1'b0, 32'h0);
    wr(CSFC_OFF_CONFIG, 32'h0);
    meas(CSFC_OFF_TMR1_COUNT, 1'b0, 32'h14);
    nominal = data;
    meas(CSFC_OFF_TMR1_COUNT, 1'b1, 32'hD);
    chk((nominal + data) >> 1, 32'h10);
    sleep_state <= 1'b1;
    meas(CSFC_OFF_TMR1_COUNT, 1'b0, 32'h0);
    chk(osc_run_r, 32'h1);
    wr(CSFC_OFF_TMR2_CTRL, 32'hC1);
    meas(CSFC_OFF_TMR2_COUNT, 1'b0, 32'h14);
    sleep_state <= 1'b0;
    meas(CSFC_OFF_TMR1_COUNT, 1'b0, 32'h0);
    wr(CSFC_OFF_TMR2_CTRL, 32'hC0);
    meas(CSFC_OFF_TMR2_COUNT, 1'b0, 32'h0);
    wr(CSFC_OFF_TMR2_CTRL, 32'hC3);
    meas(CSFC_OFF_TMR2_COUNT, 1'b0, 32'h0);
    second_timer_gate <= 1'b1;
    meas(CSFC_OFF_TMR2_COUNT, 1'b0, 32'h14);
    // Phase read while the pad is known high, then status while it is known low.
    window <= 1'b1;
    repeat (8) @(posedge clock);
    rd(CSFC_OFF_SENSE_CTRL0);
    chk(data, 32'h87);
    rd(CSFC_OFF_STATUS);
    chk(data, 32'hC);
    window <= 1'b0;
    repeat (10) @(posedge clock);
    // A reset in mid-run must clear the outputs and restore the reset values.
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    chk({27'h0, osc_run_r, high_range_r, osc_mode_r}, 32'h0);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(CSFC_OFF_TMR2_COUNT);
    chk(data, {16'h0, CSFC_RST_COUNT});
    rd(CSFC_OFF_CONFIG);
    chk(data, {23'h0, CSFC_RST_T1CS});
    stop_test();
  end

  // The whole run takes about 100 microseconds; ten times that means a hang.
  initial begin
    #1000000;
    failures++;
    stop_test();
  end
endmodule : tb_cap_sense_frequency_counter
